//--- pio_map.svh
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH

// -----------------------------------------------------------------------------
// Register word offsets
// -----------------------------------------------------------------------------
`define PIO_OFF_PORT_VALUE   3'h0
`define PIO_OFF_PIN_DIR      3'h1
`define PIO_OFF_IRQ_MASK     3'h2
`define PIO_OFF_EDGE_LATCH   3'h3
`define PIO_OFF_OUT_RAISE    3'h4
`define PIO_OFF_OUT_LOWER    3'h5

// -----------------------------------------------------------------------------
// Widths and reset values
// -----------------------------------------------------------------------------
`define PIO_DATA_W           32
`define PIO_ADDR_W           3
`define PIO_RST_DIR          32'h0000_0000
`define PIO_RST_MASK         32'h0000_0000
`define PIO_RST_EDGE         32'h0000_0000
`define PIO_RST_RDATA        32'h0000_0000

`endif

//--- pio_pkg.sv
package pio_pkg;
  typedef enum logic [1:0] {
    PIO_INPUT_ONLY,
    PIO_OUTPUT_ONLY,
    PIO_IN_AND_OUT,
    PIO_BIDIR
  } pio_mode_t;

  typedef enum logic [1:0] {
    PIO_EDGE_RISE,
    PIO_EDGE_FALL,
    PIO_EDGE_ANY
  } pio_edge_t;

  typedef enum logic {
    PIO_IRQ_LEVEL,
    PIO_IRQ_EDGE
  } pio_irq_kind_t;
endpackage

//--- pio_port.sv
`timescale 1ns/1ns
`include "pio_map.svh"

module pio_port #(
  parameter int                     WIDTH        = 32,
  parameter pio_pkg::pio_mode_t     MODE         = pio_pkg::PIO_BIDIR,
  parameter logic [31:0]            OUT_RESET    = 32'h0000_0000,
  parameter bit                     HAS_RAISE_LOWER = 1'b1,
  parameter bit                     HAS_EDGE     = 1'b1,
  parameter pio_pkg::pio_edge_t     EDGE_KIND    = pio_pkg::PIO_EDGE_RISE,
  parameter bit                     BIT_CLEAR    = 1'b1,
  parameter bit                     HAS_IRQ      = 1'b1,
  parameter pio_pkg::pio_irq_kind_t IRQ_KIND     = pio_pkg::PIO_IRQ_EDGE
) (
  input  wire logic                    mclk_i,
  input  wire logic                    rst_b_i,
  input  wire logic [`PIO_ADDR_W-1:0]  address_i,
  input  wire logic                    read_i,
  input  wire logic                    write_i,
  input  wire logic [`PIO_DATA_W-1:0]  writedata_i,
  output logic      [`PIO_DATA_W-1:0]  readdata_o,
  output logic                         irq_o,
  input  wire logic [`PIO_DATA_W-1:0]  in_port_i,
  output logic      [`PIO_DATA_W-1:0]  out_port_o,
  output logic      [`PIO_DATA_W-1:0]  out_port_oe_b_o
);
  import pio_pkg::*;

  // ---------------------------------------------------------------------------
  // Build-time features
  // ---------------------------------------------------------------------------
  localparam logic [31:0] VALID = (WIDTH >= 32) ? 32'hFFFF_FFFF
                                                : ((32'h0000_0001 << WIDTH) - 32'h0000_0001);
  localparam bit IS_BIDIR  = (MODE == PIO_BIDIR);
  localparam bit HAS_IN    = (MODE != PIO_OUTPUT_ONLY);
  localparam bit HAS_OUT   = (MODE != PIO_INPUT_ONLY);
  localparam bit EDGE_ON   = HAS_EDGE && HAS_IN;
  localparam bit IRQ_ON    = HAS_IRQ && HAS_IN;

  function automatic logic is_wr(input logic [`PIO_ADDR_W-1:0] off);
    is_wr = write_i && (address_i == off);
  endfunction

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [31:0] out_hold;
  logic [31:0] pin_dir;
  logic [31:0] irq_mask;
  logic [31:0] edge_lat;
  logic [31:0] in_prev;
  logic [31:0] next_out_hold;
  logic [31:0] next_pin_dir;
  logic [31:0] next_irq_mask;
  logic [31:0] next_edge_lat;
  logic [31:0] next_readdata;
  logic        next_irq;
  logic [31:0] in_now;
  logic [31:0] edge_hit;
  logic [31:0] irq_src;
  logic [31:0] next_oe_b;
  logic        edge_armed;

  assign in_now = in_port_i & VALID;

  always_comb begin
    next_out_hold = out_hold;
    if (HAS_OUT) begin
      if (is_wr(`PIO_OFF_PORT_VALUE)) begin
        next_out_hold = writedata_i & VALID;
      end
      if (HAS_RAISE_LOWER && is_wr(`PIO_OFF_OUT_RAISE)) begin
        next_out_hold = out_hold | (writedata_i & VALID);
      end
      if (HAS_RAISE_LOWER && is_wr(`PIO_OFF_OUT_LOWER)) begin
        next_out_hold = out_hold & ~writedata_i;
      end
    end
  end

  always_comb begin
    next_pin_dir = pin_dir;
    if (IS_BIDIR && is_wr(`PIO_OFF_PIN_DIR)) begin
      next_pin_dir = writedata_i & VALID;
    end
    next_irq_mask = irq_mask;
    if (IRQ_ON && is_wr(`PIO_OFF_IRQ_MASK)) begin
      next_irq_mask = writedata_i & VALID;
    end
  end

  // Edge detection compares against the previous sample; a set edge wins
  // over a clear in the same cycle so no event is lost.
  always_comb begin
    unique case (EDGE_KIND)
      PIO_EDGE_RISE: edge_hit = in_now & ~in_prev;
      PIO_EDGE_FALL: edge_hit = ~in_now & in_prev;
      PIO_EDGE_ANY:  edge_hit = in_now ^ in_prev;
      default:       edge_hit = 32'h0000_0000;
    endcase
    // The previous sample means nothing until one edge after reset; a pin that
    // idles high would otherwise look like a rising edge straight away.
    if (!edge_armed) begin
      edge_hit = 32'h0000_0000;
    end
    next_edge_lat = edge_lat;
    if (EDGE_ON) begin
      if (is_wr(`PIO_OFF_EDGE_LATCH)) begin
        next_edge_lat = BIT_CLEAR ? (edge_lat & ~writedata_i)
                                  : 32'h0000_0000;
      end
      next_edge_lat = (next_edge_lat | edge_hit) & VALID;
    end
  end

  always_comb begin
    irq_src  = (IRQ_KIND == PIO_IRQ_LEVEL) ? in_now : edge_lat;
    next_irq = IRQ_ON && ((irq_src & irq_mask) != 32'h0000_0000);
  end

  // Enables are low while a pin is driven; an input-only build never drives.
  always_comb begin
    if (IS_BIDIR) begin
      next_oe_b = ~next_pin_dir;
    end else if (HAS_OUT) begin
      next_oe_b = ~VALID;
    end else begin
      next_oe_b = 32'hFFFF_FFFF;
    end
  end

  // Undefined reads of absent registers return zero here.
  always_comb begin
    next_readdata = `PIO_RST_RDATA;
    if (read_i) begin
      unique case (address_i)
        `PIO_OFF_PORT_VALUE: begin
          if (MODE == PIO_OUTPUT_ONLY) begin
            next_readdata = out_hold;
          end else if (IS_BIDIR) begin
            next_readdata = out_hold & pin_dir;
          end else begin
            next_readdata = in_now;
          end
        end
        `PIO_OFF_PIN_DIR:    next_readdata = pin_dir;
        `PIO_OFF_IRQ_MASK:   next_readdata = irq_mask;
        `PIO_OFF_EDGE_LATCH: next_readdata = edge_lat;
        default:             next_readdata = `PIO_RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_hold        <= OUT_RESET & VALID;
      pin_dir         <= `PIO_RST_DIR;
      irq_mask        <= `PIO_RST_MASK;
      edge_lat        <= `PIO_RST_EDGE;
      in_prev         <= 32'h0000_0000;
      edge_armed      <= 1'b0;
      readdata_o      <= `PIO_RST_RDATA;
      irq_o           <= 1'b0;
      out_port_o      <= OUT_RESET & VALID;
      out_port_oe_b_o <= 32'hFFFF_FFFF;
    end else begin
      out_hold        <= next_out_hold;
      pin_dir         <= next_pin_dir;
      irq_mask        <= next_irq_mask;
      edge_lat        <= next_edge_lat;
      in_prev         <= in_now;
      edge_armed      <= 1'b1;
      readdata_o      <= next_readdata;
      irq_o           <= next_irq;
      out_port_o      <= next_out_hold;
      out_port_oe_b_o <= next_oe_b;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_dir_reset;
    @(posedge mclk_i) $rose(rst_b_i) |-> pin_dir == 32'h0000_0000;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");

  property p_mask_reset;
    @(posedge mclk_i) $rose(rst_b_i) |-> irq_mask == 32'h0000_0000;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not cleared");

  property p_data_write;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (HAS_OUT && write_i && address_i == `PIO_OFF_PORT_VALUE)
      |=> out_port_o == ($past(writedata_i) & VALID);
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write lost");

  property p_in_only_hold;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (MODE == PIO_INPUT_ONLY) |=> $stable(out_hold);
  endproperty
  a_in_only_hold: assert property (p_in_only_hold) else $error("input-only output moved");

  property p_pin_release;
    @(posedge mclk_i) disable iff (!rst_b_i)
      IS_BIDIR |=> out_port_oe_b_o == ~pin_dir;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin enable wrong");

  property p_raise;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (HAS_OUT && HAS_RAISE_LOWER && write_i && address_i == `PIO_OFF_OUT_RAISE)
      |=> (out_hold & ($past(writedata_i) & VALID)) == ($past(writedata_i) & VALID);
  endproperty
  a_raise: assert property (p_raise) else $error("raise failed");

  property p_lower;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (HAS_OUT && HAS_RAISE_LOWER && write_i && address_i == `PIO_OFF_OUT_LOWER)
      |=> (out_hold & $past(writedata_i)) == 32'h0000_0000;
  endproperty
  a_lower: assert property (p_lower) else $error("lower failed");

  property p_latch_hold;
    @(posedge mclk_i) disable iff (!rst_b_i)
      !(write_i && address_i == `PIO_OFF_EDGE_LATCH)
      |=> ((edge_lat & $past(edge_lat)) == $past(edge_lat));
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch bit dropped");

  property p_clear_all;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (EDGE_ON && !BIT_CLEAR && is_wr(`PIO_OFF_EDGE_LATCH))
      |=> edge_lat == ($past(edge_hit) & VALID);
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear-all failed");

  property p_irq;
    @(posedge mclk_i) disable iff (!rst_b_i)
      ##1 irq_o == (IRQ_ON && (($past(irq_src) & $past(irq_mask)) != 32'h0000_0000));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_read_port;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (read_i && address_i == `PIO_OFF_PORT_VALUE && !IS_BIDIR)
      |=> readdata_o == ((MODE == PIO_OUTPUT_ONLY) ? $past(out_hold) : $past(in_now));
  endproperty
  a_read_port: assert property (p_read_port) else $error("port value read wrong");

  property p_dir_write;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (write_i && address_i == `PIO_OFF_PIN_DIR)
      |=> pin_dir == (IS_BIDIR ? ($past(writedata_i) & VALID) : 32'h0000_0000);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write wrong");

  property p_mask_write;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (write_i && address_i == `PIO_OFF_IRQ_MASK)
      |=> irq_mask == (IRQ_ON ? ($past(writedata_i) & VALID) : 32'h0000_0000);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write wrong");

  property p_bit_clear;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (EDGE_ON && BIT_CLEAR && write_i && address_i == `PIO_OFF_EDGE_LATCH)
      |=> ((edge_lat & $past(writedata_i) & ~$past(edge_hit)) == 32'h0000_0000)
          && ((edge_lat & ~$past(writedata_i) & ~$past(edge_hit))
              == ($past(edge_lat) & ~$past(writedata_i) & ~$past(edge_hit)));
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

  property p_upper_zero;
    @(posedge mclk_i) disable iff (!rst_b_i)
      ((readdata_o | out_port_o | pin_dir) & ~VALID) == 32'h0000_0000
      && ((irq_mask | edge_lat) & ~VALID) == 32'h0000_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("bits above width set");

  property p_strobe_absent;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (!HAS_RAISE_LOWER && write_i
       && (address_i == `PIO_OFF_OUT_RAISE || address_i == `PIO_OFF_OUT_LOWER))
      |=> $stable(out_hold);
  endproperty
  a_strobe_absent: assert property (p_strobe_absent) else $error("absent strobe acted");

  c_irq:    cover property (@(posedge mclk_i) disable iff (!rst_b_i) $rose(irq_o));
  c_edge:   cover property (@(posedge mclk_i) disable iff (!rst_b_i) edge_hit != 32'h0000_0000);
  c_drive:  cover property (@(posedge mclk_i) disable iff (!rst_b_i) pin_dir != 32'h0000_0000);
  c_clear:  cover property (@(posedge mclk_i) disable iff (!rst_b_i)
                            EDGE_ON && !BIT_CLEAR && write_i && address_i == `PIO_OFF_EDGE_LATCH);
endmodule // pio_port

//--- pio_pin_model.sv
`timescale 1ns/1ns
// ----------
// Pin model
// ----------
module pio_pin_model (
  input  wire logic [31:0] out_port_i,
  input  wire logic [31:0] oe_b_i,
  input  wire logic [31:0] ext_i,
  output logic      [31:0] pin_o
);
  // A released pin follows the outside driver, a driven pin shows the port's own bit.
  assign pin_o = (oe_b_i & ext_i) | (~oe_b_i & out_port_i);
endmodule // pio_pin_model

//--- parallel_io_register_port_tb.sv
`timescale 1ns/1ns
`include "pio_map.svh"
// ----------
// Bench
// ----------
module parallel_io_register_port_tb;
  import pio_pkg::*;
  localparam int          W = 8;
  localparam logic [31:0] M = 32'h0000_00FF;
  logic        mclk_i, rst_b_i, read_i, write_i, irq_o;
  logic [2:0]  address_i;
  logic [31:0] writedata_i, readdata_o, in_port_i, out_port_o, out_port_oe_b_o;
  logic [31:0] ext, wv, lfsr_q, m_out, m_dir, m_mask, m_edge;
  int          n_errors, checked;
  logic [31:0] rdata_in, rdata_out, out_in, out_out, oe_in, oe_out, m_oo, m_edge_in;
  logic        irq_in, irq_out;

  pio_port #(.WIDTH(W)) uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .irq_o(irq_o), .in_port_i(in_port_i), .out_port_o(out_port_o),
    .out_port_oe_b_o(out_port_oe_b_o));
  pio_pin_model pins (.out_port_i(out_port_o), .oe_b_i(out_port_oe_b_o), .ext_i(ext),
    .pin_o(in_port_i));
  // A clear-all, level-interrupt input-only port and an output-only port
  // without raise and lower strobes share the bus with the main instance.
  pio_port #(.WIDTH(W), .MODE(PIO_INPUT_ONLY), .BIT_CLEAR(1'b0), .IRQ_KIND(PIO_IRQ_LEVEL))
    uut_in (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(rdata_in), .irq_o(irq_in),
    .in_port_i(ext), .out_port_o(out_in), .out_port_oe_b_o(oe_in));
  pio_port #(.WIDTH(W), .MODE(PIO_OUTPUT_ONLY), .HAS_RAISE_LOWER(1'b0))
    uut_out (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(rdata_out), .irq_o(irq_out),
    .in_port_i(ext), .out_port_o(out_out), .out_port_oe_b_o(oe_out));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rnd();
    lfsr_q = lfsr_next(lfsr_q);
    wv = lfsr_q;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    write_i <= 1'b1;
    address_i <= a;
    writedata_i <= d;
    @(posedge mclk_i);
    write_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input string nm, input logic [31:0] e);
    @(posedge mclk_i);
    read_i <= 1'b1;
    address_i <= a;
    @(posedge mclk_i);
    read_i <= 1'b0;
    #1 chk(nm, e, readdata_o);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (4000) @(posedge mclk_i);
    n_errors++;
    give_verdict();
  end
  initial begin
    {rst_b_i, read_i, write_i, address_i, writedata_i, ext} = '0;
    {m_out, m_dir, m_mask, m_edge, m_oo, m_edge_in, n_errors, checked} = '0;
    lfsr_q = 32'h0001_3573;
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    #1 chk("oe_b", 32'hFFFF_FFFF, out_port_oe_b_o);
    chk("oe_i", 32'hFFFF_FFFF, oe_in);
    rd(`PIO_OFF_PIN_DIR, "dir", 32'h0);
    rd(`PIO_OFF_IRQ_MASK, "mask", 32'h0);
    rd(`PIO_OFF_EDGE_LATCH, "edge", 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      rnd();
      m_out = wv & M;
      wr(`PIO_OFF_PORT_VALUE, wv);
      m_oo = m_out;
      chk("out", m_out, out_port_o);
      chk("out_o", m_oo, out_out);
      chk("out_i", 32'h0, out_in);
      rnd();
      m_dir = wv & M;
      wr(`PIO_OFF_PIN_DIR, wv);
      chk("oe_b", ~m_dir, out_port_oe_b_o);
      chk("oe_o", ~M, oe_out);
      chk("oe_i", 32'hFFFF_FFFF, oe_in);
      rd(`PIO_OFF_PIN_DIR, "dir", m_dir);
      chk("dir_o", 32'h0, rdata_out);
      rd(`PIO_OFF_PORT_VALUE, "data", m_out & m_dir);
      chk("data_o", m_oo, rdata_out);
      chk("data_i", ext & M, rdata_in);
      rnd();
      m_out = m_out | (wv & M);
      wr(`PIO_OFF_OUT_RAISE, wv);
      chk("raise", m_out, out_port_o);
      chk("raise_o", m_oo, out_out);
      rnd();
      m_out = m_out & ~wv;
      wr(`PIO_OFF_OUT_LOWER, wv);
      chk("lower", m_out, out_port_o);
      chk("lower_o", m_oo, out_out);
      chk("lower_i", 32'h0, out_in);
    end
    rd(`PIO_OFF_OUT_RAISE, "raise_rd", 32'h0);
    rd(`PIO_OFF_OUT_LOWER, "lower_rd", 32'h0);
    rd(3'h6, "unmapped", 32'h0);
    $display("test data done");
    wr(`PIO_OFF_PIN_DIR, 32'h0);
    rnd();
    m_mask = wv & M;
    wr(`PIO_OFF_IRQ_MASK, wv);
    rd(`PIO_OFF_IRQ_MASK, "mask", m_mask);
    chk("mask_i", m_mask, rdata_in);
    chk("mask_o", 32'h0, rdata_out);
    repeat (3) @(posedge mclk_i);
    wr(`PIO_OFF_EDGE_LATCH, 32'hFFFF_FFFF);
    m_edge = '0;
    m_edge_in = '0;
    for (int i = 0; i < 6; i++) begin
      rnd();
      m_edge = m_edge | (wv & ~ext & M);
      m_edge_in = m_edge_in | (wv & ~ext & M);
      @(posedge mclk_i);
      ext <= wv;
      repeat (3) @(posedge mclk_i);
      #1 chk("irq", {31'h0, |(m_edge & m_mask)}, {31'h0, irq_o});
      chk("irq_i", {31'h0, |(ext & M & m_mask)}, {31'h0, irq_in});
      chk("irq_out", 32'h0, {31'h0, irq_out});
      rd(`PIO_OFF_EDGE_LATCH, "edge", m_edge);
      chk("edge_i", m_edge_in, rdata_in);
      rd(`PIO_OFF_PORT_VALUE, "data_z", 32'h0);
      chk("data_i", ext & M, rdata_in);
      rnd();
      m_edge = m_edge & ~wv;
      wr(`PIO_OFF_EDGE_LATCH, wv);
      m_edge_in = '0;
      rd(`PIO_OFF_EDGE_LATCH, "edge_clr", m_edge);
      chk("edge_clr_i", m_edge_in, rdata_in);
    end
    wr(`PIO_OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge mclk_i);
    #1 chk("irq_off", 32'h0, {31'h0, irq_o});
    chk("irq_off_i", 32'h0, {31'h0, irq_in});
    $display("test edge done");
    give_verdict();
  end
endmodule // parallel_io_register_port_tb
